/* rtl/sfm_pkg.sv */
package sfm_pkg;
  // Parameter byte addresses and contents
  localparam logic [7:0] PA_PWR_DOWN_CODE  = 8'h66;
  localparam logic [7:0] PA_DEEP_SLEEP     = 8'h67;
  localparam logic [7:0] PA_QUAD_SEQ       = 8'h68;
  localparam logic [7:0] PA_CONT_EXIT      = 8'h69;
  localparam logic [7:0] PA_CONT_ENTRY_QE  = 8'h6A;
  localparam logic [7:0] PA_RESERVED       = 8'h6B;
  localparam logic [7:0] PA_STATUS_WREN    = 8'h6C;
  localparam logic [7:0] PA_SOFT_RESET     = 8'h6D;
  localparam logic [7:0] PA_WIDE_EXIT      = 8'h6E;
  localparam logic [7:0] PA_WIDE_ENTRY     = 8'h6F;
  localparam logic [7:0] PV_PWR_DOWN_CODE  = 8'hFF;
  localparam logic [7:0] PV_DEEP_SLEEP     = 8'hFF;
  localparam logic [7:0] PV_QUAD_SEQ       = 8'h29;
  localparam logic [7:0] PV_CONT_EXIT      = 8'hC2;
  localparam logic [7:0] PV_CONT_ENTRY_QE  = 8'h5C;
  localparam logic [7:0] PV_RESERVED       = 8'hFF;
  localparam logic [7:0] PV_STATUS_WREN    = 8'hF0;
  localparam logic [7:0] PV_SOFT_RESET     = 8'h30;
  localparam logic [7:0] PV_WIDE_EXIT      = 8'hC0;
  localparam logic [7:0] PV_WIDE_ENTRY     = 8'h80;
  localparam logic [7:0] PV_UNMAPPED       = 8'hFF;
  // Instruction codes
  localparam logic [7:0] OP_WREN      = 8'h06;
  localparam logic [7:0] OP_QUAD_EN   = 8'h38;
  localparam logic [7:0] OP_QUAD_EXIT = 8'hFF;
  localparam logic [7:0] OP_RST_EN    = 8'h66;
  localparam logic [7:0] OP_RST       = 8'h99;
  localparam logic [7:0] OP_WR_STAT   = 8'h01;
  localparam logic [7:0] OP_WR_CFG    = 8'h31;
  // Continuous read mode match
  localparam logic [3:0] MODE_CONT_NIB = 4'hA;
  // Device register fields and reset values
  localparam int         CFG_QE_BIT   = 1;
  localparam int         SR_WEL_BIT   = 1;
  localparam logic [7:0] CFG_RST      = 8'h00;
  localparam logic [5:0] SR_NV_RST    = 6'h00;
  // Host register offsets
  localparam logic [7:0] HR_CMD   = 8'h00;
  localparam logic [7:0] HR_MODE  = 8'h04;
  localparam logic [7:0] HR_PRM   = 8'h08;
  localparam logic [7:0] HR_STAT  = 8'h0C;
  localparam logic [7:0] HR_DATA  = 8'h10;
  // Host status fields
  localparam int ST_BUSY = 0;
  localparam int ST_QUAD = 1;
  localparam int ST_CONT = 2;
  localparam int ST_QE   = 3;
  localparam int ST_WEL  = 4;
  localparam int ST_REF  = 5;
  // Host sequencer states
  typedef enum logic [1:0] {
    SFM_H_IDLE = 2'b00,
    SFM_H_MAIN = 2'b01,
    SFM_H_WAIT = 2'b11
  } sfm_hst_t;
endpackage

/* rtl/sfm_link_if.sv */
`timescale 1ns/1ps
interface sfm_link_if;
  logic       cmd_vld;
  logic [7:0] cmd_op;
  logic [7:0] cmd_arg;
  logic       mode_vld;
  logic [7:0] mode_bits;
  logic       prm_rd;
  logic [7:0] prm_addr;
  logic [7:0] prm_data;
  logic       prm_ack;
  logic       quad_on;
  logic       cont_on;
  logic       qe_on;
  logic       wel_on;
  modport dev (
    input  cmd_vld, cmd_op, cmd_arg, mode_vld, mode_bits, prm_rd,
           prm_addr,
    output prm_data, prm_ack, quad_on, cont_on, qe_on, wel_on
  );
  modport hst (
    output cmd_vld, cmd_op, cmd_arg, mode_vld, mode_bits, prm_rd,
           prm_addr,
    input  prm_data, prm_ack, quad_on, cont_on, qe_on, wel_on
  );
endinterface

/* rtl/sfm_dev.sv */
`timescale 1ns/1ps
module sfm_dev (
  // Clock and reset
  input  wire logic   i_core_clk,
  input  wire logic   i_rst,
  input  wire logic   i_ce,
  // Link to host
  sfm_link_if.dev     link,
  // User side
  output logic        o_quad_mode,
  output logic        o_cont_read,
  output logic [7:0]  o_status1,
  output logic [7:0]  o_config
);
  import sfm_pkg::*;

  logic       quad_q;
  logic       quad_d;
  logic       cont_q;
  logic       cont_d;
  logic       wel_q;
  logic       wel_d;
  logic       arm_q;
  logic       arm_d;
  logic [5:0] sr_nv_q;
  logic [5:0] sr_nv_d;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] prm_q;
  logic [7:0] prm_d;
  logic       ack_q;
  logic       ack_d;

  // Fixed parameter content, writes have no path here
  function automatic logic [7:0] prm_rom(input logic [7:0] a);
    logic [7:0] v;
    v = PV_UNMAPPED;
    case (a)
      PA_PWR_DOWN_CODE: v = PV_PWR_DOWN_CODE;
      PA_DEEP_SLEEP:    v = PV_DEEP_SLEEP;
      PA_QUAD_SEQ:      v = PV_QUAD_SEQ;
      PA_CONT_EXIT:     v = PV_CONT_EXIT;
      PA_CONT_ENTRY_QE: v = PV_CONT_ENTRY_QE;
      PA_RESERVED:      v = PV_RESERVED;
      PA_STATUS_WREN:   v = PV_STATUS_WREN;
      PA_SOFT_RESET:    v = PV_SOFT_RESET;
      PA_WIDE_EXIT:     v = PV_WIDE_EXIT;
      PA_WIDE_ENTRY:    v = PV_WIDE_ENTRY;
      default:          v = PV_UNMAPPED;
    endcase
    return v;
  endfunction

  // Mode and register next state
  always_comb
  begin
    quad_d  = quad_q;
    cont_d  = cont_q;
    wel_d   = wel_q;
    arm_d   = arm_q;
    sr_nv_d = sr_nv_q;
    cfg_d   = cfg_q;
    // Commands are not decoded while in continuous read
    if (link.cmd_vld && !cont_q)
    begin
      arm_d = 1'b0;
      case (link.cmd_op)
        OP_WREN:
        begin
          wel_d = 1'b1;
        end
        OP_RST_EN:
        begin
          arm_d = 1'b1;
        end
        OP_RST:
        begin
          if (arm_q)
          begin
            quad_d = 1'b0;
            cont_d = 1'b0;
            wel_d  = 1'b0;
          end
        end
        OP_QUAD_EN:
        begin
          if (cfg_q[CFG_QE_BIT])
          begin
            quad_d = 1'b1;
          end
        end
        OP_QUAD_EXIT:
        begin
          quad_d = 1'b0;
        end
        OP_WR_STAT:
        begin
          if (wel_q)
          begin
            sr_nv_d = link.cmd_arg[7:2];
          end
          wel_d = 1'b0;
        end
        OP_WR_CFG:
        begin
          if (wel_q)
          begin
            cfg_d = link.cmd_arg;
          end
          wel_d = 1'b0;
        end
        default:
        begin
          arm_d = 1'b0;
        end
      endcase
    end
    // Mode bits after a read address select continuous read, only while the QE bit is set
    if (link.mode_vld && cfg_q[CFG_QE_BIT])
    begin
      cont_d = (link.mode_bits[7:4] == MODE_CONT_NIB);
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      quad_q  <= 1'b0;
      cont_q  <= 1'b0;
      wel_q   <= 1'b0;
      arm_q   <= 1'b0;
      sr_nv_q <= SR_NV_RST;
      cfg_q   <= CFG_RST;
    end
    else if (i_ce)
    begin
      quad_q  <= quad_d;
      cont_q  <= cont_d;
      wel_q   <= wel_d;
      arm_q   <= arm_d;
      sr_nv_q <= sr_nv_d;
      cfg_q   <= cfg_d;
    end
  end

  // Parameter read answer, one cycle after the request
  always_comb
  begin
    ack_d = link.prm_rd;
    prm_d = prm_q;
    if (link.prm_rd)
    begin
      prm_d = prm_rom(link.prm_addr);
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ack_q <= 1'b0;
      prm_q <= PV_UNMAPPED;
    end
    else if (i_ce)
    begin
      ack_q <= ack_d;
      prm_q <= prm_d;
    end
  end

  // Outputs
  assign link.prm_data = prm_q;
  assign link.prm_ack  = ack_q;
  assign link.quad_on  = quad_q;
  assign link.cont_on  = cont_q;
  assign link.qe_on    = cfg_q[CFG_QE_BIT];
  assign link.wel_on   = wel_q;
  assign o_quad_mode   = quad_q;
  assign o_cont_read   = cont_q;
  assign o_status1     = {sr_nv_q, wel_q, 1'b0};
  assign o_config      = cfg_q;

endmodule // sfm_dev

/* rtl/sfm_hst.sv */
`timescale 1ns/1ps
module sfm_hst (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // Link to device
  sfm_link_if.hst          link
);
  import sfm_pkg::*;

  sfm_hst_t    st_q;
  sfm_hst_t    st_d;
  logic [7:0]  op_q;
  logic [7:0]  op_d;
  logic [7:0]  arg_q;
  logic [7:0]  arg_d;
  logic        cv_q;
  logic        cv_d;
  logic [7:0]  cop_q;
  logic [7:0]  cop_d;
  logic        mv_q;
  logic        mv_d;
  logic [7:0]  mb_q;
  logic [7:0]  mb_d;
  logic        pr_q;
  logic        pr_d;
  logic [7:0]  pa_q;
  logic [7:0]  pa_d;
  logic [7:0]  dat_q;
  logic [7:0]  dat_d;
  logic        ref_q;
  logic        ref_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [5:0]  stat;

  assign stat = {ref_q, link.wel_on, link.qe_on, link.cont_on,
                 link.quad_on, (st_q != SFM_H_IDLE)};

  always_comb
  begin
    st_d  = st_q;
    op_d  = op_q;
    arg_d = arg_q;
    cv_d  = 1'b0;
    cop_d = cop_q;
    mv_d  = 1'b0;
    mb_d  = mb_q;
    pr_d  = 1'b0;
    pa_d  = pa_q;
    dat_d = dat_q;
    ref_d = ref_q;
    rd_d  = rd_q;
    if (i_rd)
    begin
      case (i_addr)
        HR_STAT: rd_d = {26'h0, stat};
        HR_DATA: rd_d = {24'h0, dat_q};
        default: rd_d = 32'h0;
      endcase
      if (i_addr == HR_STAT)
      begin
        ref_d = 1'b0;
      end
    end
    case (st_q)
      SFM_H_IDLE:
      begin
        if (i_wr && i_addr == HR_CMD)
        begin
          op_d  = i_wdata[7:0];
          arg_d = i_wdata[15:8];
          cv_d  = 1'b1;
          cop_d = i_wdata[7:0];
          if ((i_wdata[7:0] == OP_RST || i_wdata[7:0] == OP_RST_EN)
              && link.cont_on)
          begin
            cv_d  = 1'b0;
            ref_d = 1'b1;
          end
          else if (i_wdata[7:0] == OP_RST)
          begin
            cop_d = OP_RST_EN;
            st_d  = SFM_H_MAIN;
          end
          else if (i_wdata[7:0] == OP_WR_STAT ||
                   i_wdata[7:0] == OP_WR_CFG)
          begin
            cop_d = OP_WREN;
            st_d  = SFM_H_MAIN;
          end
        end
        else if (i_wr && i_addr == HR_MODE)
        begin
          mv_d = 1'b1;
          mb_d = i_wdata[7:0];
        end
        else if (i_wr && i_addr == HR_PRM)
        begin
          pr_d = 1'b1;
          pa_d = i_wdata[7:0];
          st_d = SFM_H_WAIT;
        end
      end
      SFM_H_MAIN:
      begin
        cv_d  = 1'b1;
        cop_d = op_q;
        st_d  = SFM_H_IDLE;
        ref_d = ref_d | i_wr;
      end
      SFM_H_WAIT:
      begin
        if (link.prm_ack)
        begin
          dat_d = link.prm_data;
          st_d  = SFM_H_IDLE;
        end
        ref_d = ref_d | i_wr;
      end
      default:
      begin
        st_d = SFM_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      st_q  <= SFM_H_IDLE;
      op_q  <= 8'h00;
      arg_q <= 8'h00;
      cv_q  <= 1'b0;
      cop_q <= 8'h00;
      mv_q  <= 1'b0;
      mb_q  <= 8'h00;
      pr_q  <= 1'b0;
      pa_q  <= 8'h00;
      dat_q <= 8'h00;
      ref_q <= 1'b0;
      rd_q  <= 32'h0;
    end
    else if (i_ce)
    begin
      st_q  <= st_d;
      op_q  <= op_d;
      arg_q <= arg_d;
      cv_q  <= cv_d;
      cop_q <= cop_d;
      mv_q  <= mv_d;
      mb_q  <= mb_d;
      pr_q  <= pr_d;
      pa_q  <= pa_d;
      dat_q <= dat_d;
      ref_q <= ref_d;
      rd_q  <= rd_d;
    end
  end

  assign link.cmd_vld   = cv_q;
  assign link.cmd_op    = cop_q;
  assign link.cmd_arg   = arg_q;
  assign link.mode_vld  = mv_q;
  assign link.mode_bits = mb_q;
  assign link.prm_rd    = pr_q;
  assign link.prm_addr  = pa_q;
  assign o_rdata        = rd_q;

endmodule // sfm_hst

/* bench/sfm_link_chk.sv */
`timescale 1ns/1ps
module sfm_link_chk
  import sfm_pkg::*;
(
  // Clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       i_ce,
  // Link signals
  input wire logic       cmd_vld,
  input wire logic [7:0] cmd_op,
  input wire logic       mode_vld,
  input wire logic [7:0] mode_bits,
  input wire logic       prm_rd,
  input wire logic [7:0] prm_addr,
  input wire logic [7:0] prm_data,
  input wire logic       prm_ack,
  input wire logic       quad_on,
  input wire logic       cont_on,
  input wire logic       qe_on,
  input wire logic       wel_on
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic cmd_ok;
  assign cmd_ok = i_ce && cmd_vld && !cont_on;
  property p_ack;
    i_ce && prm_rd |=> prm_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_rsvd;
    i_ce && prm_rd && prm_addr == 8'h6B |=> prm_data == 8'hFF;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("bad 6B");
  property p_wexit;
    i_ce && prm_rd && prm_addr == 8'h6E |=> prm_data == 8'hC0;
  endproperty
  a_wexit: assert property (p_wexit) else $error("bad 6E");
  property p_quad_en;
    cmd_ok && cmd_op == 8'h38 && qe_on |=> quad_on;
  endproperty
  a_quad_en: assert property (p_quad_en) else $error("no quad");
  property p_qe_gate;
    cmd_ok && cmd_op == 8'h38 && !qe_on && !quad_on |=> !quad_on;
  endproperty
  a_qe_gate: assert property (p_qe_gate) else $error("quad no qe");
  property p_quad_ex;
    cmd_ok && cmd_op == 8'hFF |=> !quad_on;
  endproperty
  a_quad_ex: assert property (p_quad_ex) else $error("quad stays");
  property p_rst;
    cmd_ok && cmd_op == 8'h99 && $past(cmd_ok && cmd_op == 8'h66)
      |=> !quad_on && !wel_on;
  endproperty
  a_rst: assert property (p_rst) else $error("no reset");
  property p_wel;
    cmd_ok && cmd_op == 8'h06 |=> wel_on;
  endproperty
  a_wel: assert property (p_wel) else $error("no wel");
  property p_cont_en;
    i_ce && mode_vld && qe_on && mode_bits[7:4] == 4'hA |=> cont_on;
  endproperty
  a_cont_en: assert property (p_cont_en) else $error("no cont");
  property p_cont_ex;
    i_ce && mode_vld && qe_on && mode_bits[7:4] != 4'hA |=> !cont_on;
  endproperty
  a_cont_ex: assert property (p_cont_ex) else $error("cont on");
endmodule // sfm_link_chk

/* bench/test_sfdp_mode_control_params.sv */
`timescale 1ns/1ps
module test_sfdp_mode_control_params;
  import sfm_pkg::*;
  logic        clk;
  logic        rst;
  logic        ce;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic        dev_quad;
  logic        dev_cont;
  logic [7:0]  dev_stat1;
  logic [7:0]  dev_cfg;
  int          fails;
  int          tests_run;
  logic [7:0]  prm_got [0:10];
  logic [7:0]  prm_exp [0:10] = '{8'hFF, 8'hFF, 8'h29, 8'hC2, 8'h5C,
    8'hFF, 8'hF0, 8'h30, 8'hC0, 8'h80, 8'hFF};

  sfm_link_if lb ();
  sfm_dev u_sfm_dev (.i_core_clk(clk), .i_rst(rst), .i_ce(ce),
    .link(lb.dev), .o_quad_mode(dev_quad), .o_cont_read(dev_cont),
    .o_status1(dev_stat1), .o_config(dev_cfg));
  sfm_hst u_sfm_hst (.i_core_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .link(lb.hst));
  sfm_link_chk u_sfm_link_chk (.i_core_clk(clk), .i_rst(rst),
    .i_ce(ce), .cmd_vld(lb.cmd_vld), .cmd_op(lb.cmd_op),
    .mode_vld(lb.mode_vld), .mode_bits(lb.mode_bits),
    .prm_rd(lb.prm_rd), .prm_addr(lb.prm_addr),
    .prm_data(lb.prm_data), .prm_ack(lb.prm_ack),
    .quad_on(lb.quad_on), .cont_on(lb.cont_on), .qe_on(lb.qe_on),
    .wel_on(lb.wel_on));

  always #5 clk = ~clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task complete_run;
    $display("checks=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    rv = rdata;
    @(posedge clk);
  endtask

  task wait_idle;
    int n;
    for (n = 0; n < 20; n++)
    begin
      rd_reg(HR_STAT);
      if (rv[ST_BUSY] === 1'b0)
        break;
    end
    if (n == 20)
    begin
      fails++;
      complete_run();
    end
  endtask

  task do_op(input logic [7:0] a, input logic [31:0] d);
    wr_reg(a, d);
    wait_idle();
    rd_reg(HR_STAT);
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Parameter bytes 66h..70h
    for (int i = 0; i < 11; i++)
    begin
      do_op(HR_PRM, 32'h66 + 32'(i));
      rd_reg(HR_DATA);
      prm_got[i] = rv[7:0];
      chk(rv, {24'h0, prm_exp[i]});
    end
    chk(prm_got[1], 8'hFF);
    chk(prm_got[3][1], 1'b1);
    chk(prm_got[4][6:4], 3'h5);
    chk(prm_got[4][7], 1'b0);
    chk(prm_got[5], 8'hFF);
    chk(prm_got[8], 8'hC0);
    chk(prm_got[9], 8'h80);
    rd_reg(8'h20);
    chk(rv, 32'h0);
    $display("test params done");
    // Quad entry and exit
    do_op(HR_MODE, 32'hA5);
    chk(rv[ST_CONT], 1'b0);
    do_op(HR_CMD, 32'h38);
    chk(rv[ST_QUAD], 1'b0);
    do_op(HR_CMD, 32'h231);
    chk(rv[ST_QE], 1'b1);
    chk(rv[ST_WEL], 1'b0);
    do_op(HR_CMD, 32'h38);
    chk(rv[ST_QUAD], 1'b1);
    chk(dev_quad, 1'b1);
    do_op(HR_CMD, 32'hFF);
    chk(rv[ST_QUAD], 1'b0);
    do_op(HR_CMD, 32'h38);
    do_op(HR_CMD, 32'h99);
    chk(rv[ST_QUAD], 1'b0);
    chk(rv[ST_QE], 1'b1);
    chk(dev_cfg, 8'h02);
    do_op(HR_CMD, 32'hA801);
    chk(rv[ST_WEL], 1'b0);
    chk(dev_stat1, 8'hA8);
    $display("test quad done");
    // Continuous read
    do_op(HR_MODE, 32'hA5);
    chk(rv[ST_CONT], 1'b1);
    chk(dev_cont, 1'b1);
    wr_reg(HR_CMD, 32'h99);
    rd_reg(HR_STAT);
    chk(rv[ST_REF], 1'b1);
    rd_reg(HR_STAT);
    chk(rv[ST_REF], 1'b0);
    chk(rv[ST_CONT], 1'b1);
    do_op(HR_MODE, 32'h5A);
    chk(rv[ST_CONT], 1'b0);
    chk(dev_cont, 1'b0);
    // Clock enable low: the strobe is not taken
    ce <= 1'b0;
    wr_reg(HR_CMD, 32'h38);
    ce <= 1'b1;
    rd_reg(HR_STAT);
    chk(rv[ST_QUAD], 1'b0);
    chk(dev_quad, 1'b0);
    $display("test cont done");
    complete_run();
  end
endmodule // test_sfdp_mode_control_params
